//--- patw_far.sv
`timescale 1ns/1ps
module patw_far
  import patw_pkg::*;
(
  input wire logic pclk,
  output patw_req_s pri_req,
  output patw_req_s sec_req,
  output patw_req_s out_req,
  output logic base_we,
  output logic base_sec,
  output logic [31:0] base_wdata
);
  // ==========================================================
  // one-cycle requests; released lines show inverted data
  initial begin
    pri_req = '0;
    sec_req = '0;
    out_req = '0;
    base_we = 1'b0;
    base_sec = 1'b0;
    base_wdata = '0;
  end
  task automatic send(input int unsigned w, input logic [31:0] a);
    @(posedge pclk);
    if (w == 0) pri_req <= '{1'b1, a};
    else if (w == 1) sec_req <= '{1'b1, a};
    else out_req <= '{1'b1, a};
    @(posedge pclk);
    pri_req <= '{1'b0, ~a};
    sec_req <= '{1'b0, ~a};
    out_req <= '{1'b0, ~a};
  endtask
  task automatic cfg(input logic sec, input logic [31:0] d);
    @(posedge pclk);
    base_we <= 1'b1;
    base_sec <= sec;
    base_wdata <= d;
    @(posedge pclk);
    base_we <= 1'b0;
    base_wdata <= ~d;
  endtask
endmodule

//--- patw_monitor.sv
`timescale 1ns/1ps
module patw_monitor
  import patw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pready,
  input wire logic pslverr,
  input wire patw_req_s pri_in_req,
  input wire patw_req_s sec_in_req,
  input wire patw_req_s out_req,
  input wire patw_in_ans_s pri_in_ans,
  input wire patw_in_ans_s sec_in_ans,
  input wire patw_out_ans_s out_ans
);
  // ==========================================================
  // window decode
  wire logic in_mem = (out_req.addr & BIG_WIN_MASK) == MEM_WIN_BASE;
  wire logic in_dual = (out_req.addr & BIG_WIN_MASK) == DUAL_WIN_BASE;
  wire logic in_io = (out_req.addr & IO_WIN_MASK) == IO_WIN_BASE;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pri_idle_quiet: assert property (!pri_in_req.valid |=> pri_in_ans == '0)
    else $error("primary answer without request");
  chk_sec_idle_quiet: assert property (!sec_in_req.valid |=> sec_in_ans == '0)
    else $error("secondary answer without request");
  chk_pri_hit_offset: assert property (pri_in_ans.hit |->
    pri_in_ans.addr[11:0] == $past(pri_in_req.addr[11:0]))
    else $error("primary offset lost");
  chk_sec_hit_offset: assert property (sec_in_ans.hit |->
    sec_in_ans.addr[11:0] == $past(sec_in_req.addr[11:0]))
    else $error("secondary offset lost");
  chk_out_miss_zero: assert property (out_req.valid && !in_mem && !in_io
    && !in_dual |=> out_ans == '0)
    else $error("outbound miss answered");
  chk_out_mem_map: assert property (out_req.valid && in_mem |=>
    out_ans.kind == PATW_OUT_MEM &&
    out_ans.addr_lo[25:0] == $past(out_req.addr[25:0]))
    else $error("memory window mapping wrong");
  chk_out_io_map: assert property (out_req.valid && in_io |=>
    out_ans.kind == PATW_OUT_IO &&
    out_ans.addr_lo[15:0] == $past(out_req.addr[15:0]))
    else $error("io window mapping wrong");
  chk_out_dual_map: assert property (out_req.valid && in_dual |=>
    out_ans.kind == PATW_OUT_DUAL &&
    out_ans.addr_lo[25:0] == $past(out_req.addr[25:0]))
    else $error("dual window mapping wrong");
  chk_apb_no_wait: assert property (psel |-> pready && !pslverr)
    else $error("apb wait or error");
  cov_pri_hit: cover property (pri_in_ans.hit);
  cov_sec_hit: cover property (sec_in_ans.hit);
  cov_dual: cover property (out_ans.kind == PATW_OUT_DUAL);
endmodule
bind patw_top patw_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .pready(pready), .pslverr(pslverr),
  .pri_in_req(pri_in_req), .sec_in_req(sec_in_req), .out_req(out_req),
  .pri_in_ans(pri_in_ans), .sec_in_ans(sec_in_ans), .out_ans(out_ans));

//--- patw_pkg.sv
package patw_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_IRQ_INFO = 8'h00;
  localparam logic [7:0] OFS_PI_BASE = 8'h04;
  localparam logic [7:0] OFS_PI_MASK = 8'h08;
  localparam logic [7:0] OFS_PI_XLAT = 8'h0c;
  localparam logic [7:0] OFS_SI_BASE = 8'h10;
  localparam logic [7:0] OFS_SI_MASK = 8'h14;
  localparam logic [7:0] OFS_SI_XLAT = 8'h18;
  localparam logic [7:0] OFS_PO_MEM = 8'h1c;
  localparam logic [7:0] OFS_PO_IO = 8'h20;
  localparam logic [7:0] OFS_PO_DUAL = 8'h24;
  localparam logic [7:0] OFS_PO_UPPER = 8'h28;
  // ==========================================================
  // reset values and fields
  localparam logic [31:0] SI_MASK_RST = 32'hffffe000;
  localparam logic [31:0] BASE_FIELD = 32'hfffff000;
  localparam logic [7:0] LINE_RST = 8'hff;
  localparam logic [7:0] PIN_RST = 8'h01;
  localparam logic [7:0] GNT_RST = 8'h00;
  localparam logic [7:0] LAT_RST = 8'h00;
  // ==========================================================
  // fixed outbound windows
  localparam logic [31:0] MEM_WIN_BASE = 32'h80000000;
  localparam logic [31:0] DUAL_WIN_BASE = 32'h84000000;
  localparam logic [31:0] BIG_WIN_MASK = 32'hfc000000;
  localparam logic [31:0] IO_WIN_BASE = 32'h90000000;
  localparam logic [31:0] IO_WIN_MASK = 32'hffff0000;

  typedef enum logic [1:0] {
    PATW_OUT_NONE = 2'b00,
    PATW_OUT_MEM = 2'b01,
    PATW_OUT_IO = 2'b10,
    PATW_OUT_DUAL = 2'b11
  } patw_kind_e;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } patw_req_s;

  typedef struct packed {
    logic hit;
    logic [31:0] addr;
  } patw_in_ans_s;

  typedef struct packed {
    patw_kind_e kind;
    logic [31:0] addr_lo;
    logic [31:0] addr_hi;
  } patw_out_ans_s;
endpackage

//--- patw_top.sv
`timescale 1ns/1ps
module patw_top
  import patw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pci_base_we,
  input wire logic pci_base_sec,
  input wire logic [31:0] pci_base_wdata,
  input wire patw_req_s pri_in_req,
  input wire patw_req_s sec_in_req,
  input wire patw_req_s out_req,
  output patw_in_ans_s pri_in_ans,
  output patw_in_ans_s sec_in_ans,
  output patw_out_ans_s out_ans
);
  logic [7:0] interrupt_line_info;
  logic [7:0] interrupt_pin_info;
  logic [7:0] min_burst_grant_info;
  logic [7:0] max_access_latency_info;
  logic [31:0] primary_inbound_window_base;
  logic [31:0] primary_inbound_window_mask;
  logic [31:0] primary_inbound_translate_value;
  logic [31:0] secondary_inbound_window_base;
  logic [31:0] secondary_inbound_window_mask;
  logic [31:0] secondary_inbound_translate_value;
  logic [31:0] primary_outbound_mem_value;
  logic [31:0] primary_outbound_io_value;
  logic [31:0] primary_outbound_dual_addr_value;
  logic [31:0] primary_outbound_upper_addr;
  logic wr_en;
  logic mapped;
  logic [31:0] next_rdata;

  // ==========================================================
  // window helpers
  function automatic logic [31:0] gate_base(input logic [31:0] mask,
                                            input logic [31:0] old,
                                            input logic [31:0] wd);
    logic [31:0] m;
    m = mask & BASE_FIELD;
    if (m == 32'h0) begin
      gate_base = old;
    end else begin
      gate_base = (wd & m) | (old & ~m);
    end
  endfunction

  function automatic patw_in_ans_s xlate_in(input patw_req_s rq,
                                            input logic [31:0] base,
                                            input logic [31:0] mask,
                                            input logic [31:0] tv);
    logic [31:0] m;
    patw_in_ans_s a;
    // only bits 31..12 of the limit take part, so a limit written with
    // low ones cannot swallow the page offset of the access
    m = mask & BASE_FIELD;
    a.hit = rq.valid && (m != 32'h0) &&
            ((rq.addr & m) == (base & m));
    // low translate bits dropped by the mask; a miss shows no address
    if (a.hit) begin
      a.addr = (tv & m) | (rq.addr & ~m);
    end else begin
      a.addr = 32'h0;
    end
    xlate_in = a;
  endfunction

  // ==========================================================
  // apb slave: zero wait states
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0;
    unique case (paddr[7:0])
      OFS_IRQ_INFO: next_rdata = {max_access_latency_info,
                                  min_burst_grant_info,
                                  interrupt_pin_info, interrupt_line_info};
      OFS_PI_BASE: next_rdata = primary_inbound_window_base;
      OFS_PI_MASK: next_rdata = primary_inbound_window_mask;
      OFS_PI_XLAT: next_rdata = primary_inbound_translate_value;
      OFS_SI_BASE: next_rdata = secondary_inbound_window_base;
      OFS_SI_MASK: next_rdata = secondary_inbound_window_mask;
      OFS_SI_XLAT: next_rdata = secondary_inbound_translate_value;
      OFS_PO_MEM: next_rdata = primary_outbound_mem_value;
      OFS_PO_IO: next_rdata = primary_outbound_io_value;
      OFS_PO_DUAL: next_rdata = primary_outbound_dual_addr_value;
      OFS_PO_UPPER: next_rdata = primary_outbound_upper_addr;
      default: mapped = 1'b0;
    endcase
    if (paddr[31:8] != 24'h0) begin
      mapped = 1'b0;
      next_rdata = 32'h0;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= mapped ? next_rdata : 32'h0;
    end
  end

  // ==========================================================
  // header information bytes, information only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_line_info <= LINE_RST;
      interrupt_pin_info <= PIN_RST;
      min_burst_grant_info <= GNT_RST;
      max_access_latency_info <= LAT_RST;
    end else if (wr_en && mapped && paddr[7:0] == OFS_IRQ_INFO) begin
      interrupt_line_info <= pwdata[7:0];
      interrupt_pin_info <= pwdata[15:8];
      min_burst_grant_info <= pwdata[23:16];
      max_access_latency_info <= pwdata[31:24];
    end
  end

  // ==========================================================
  // inbound window registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_inbound_window_mask <= 32'h0;
      primary_inbound_translate_value <= 32'h0;
      secondary_inbound_window_mask <= SI_MASK_RST;
      secondary_inbound_translate_value <= 32'h0;
    end else if (wr_en && mapped) begin
      if (paddr[7:0] == OFS_PI_MASK) begin
        primary_inbound_window_mask <= pwdata;
      end
      if (paddr[7:0] == OFS_PI_XLAT) begin
        primary_inbound_translate_value <= pwdata;
      end
      if (paddr[7:0] == OFS_SI_MASK) begin
        secondary_inbound_window_mask <= pwdata;
      end
      if (paddr[7:0] == OFS_SI_XLAT) begin
        secondary_inbound_translate_value <= pwdata;
      end
    end
  end

  // base bits outside the mask are forced to zero as well, so a
  // shrinking mask never leaves stale writable bits behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_inbound_window_base <= 32'h0;
    end else if (pci_base_we && !pci_base_sec) begin
      primary_inbound_window_base <= gate_base(primary_inbound_window_mask,
        primary_inbound_window_base, pci_base_wdata)
        & primary_inbound_window_mask & BASE_FIELD;
    end else if (wr_en && mapped && paddr[7:0] == OFS_PI_BASE) begin
      primary_inbound_window_base <= gate_base(primary_inbound_window_mask,
        primary_inbound_window_base, pwdata)
        & primary_inbound_window_mask & BASE_FIELD;
    end else begin
      primary_inbound_window_base <= primary_inbound_window_base
        & primary_inbound_window_mask & BASE_FIELD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_inbound_window_base <= 32'h0;
    end else if (pci_base_we && pci_base_sec) begin
      secondary_inbound_window_base <= gate_base(
        secondary_inbound_window_mask, secondary_inbound_window_base,
        pci_base_wdata) & secondary_inbound_window_mask & BASE_FIELD;
    end else if (wr_en && mapped && paddr[7:0] == OFS_SI_BASE) begin
      secondary_inbound_window_base <= gate_base(
        secondary_inbound_window_mask, secondary_inbound_window_base,
        pwdata) & secondary_inbound_window_mask & BASE_FIELD;
    end else begin
      secondary_inbound_window_base <= secondary_inbound_window_base
        & secondary_inbound_window_mask & BASE_FIELD;
    end
  end

  // ==========================================================
  // outbound value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_outbound_mem_value <= 32'h0;
      primary_outbound_io_value <= 32'h0;
      primary_outbound_dual_addr_value <= 32'h0;
      primary_outbound_upper_addr <= 32'h0;
    end else if (wr_en && mapped) begin
      if (paddr[7:0] == OFS_PO_MEM) begin
        primary_outbound_mem_value <= pwdata;
      end
      if (paddr[7:0] == OFS_PO_IO) begin
        primary_outbound_io_value <= pwdata;
      end
      if (paddr[7:0] == OFS_PO_DUAL) begin
        primary_outbound_dual_addr_value <= pwdata;
      end
      if (paddr[7:0] == OFS_PO_UPPER) begin
        primary_outbound_upper_addr <= pwdata;
      end
    end
  end

  // ==========================================================
  // translation results, registered one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_in_ans <= '0;
      sec_in_ans <= '0;
    end else begin
      pri_in_ans <= xlate_in(pri_in_req, primary_inbound_window_base,
        primary_inbound_window_mask,
        primary_inbound_translate_value);
      sec_in_ans <= xlate_in(sec_in_req, secondary_inbound_window_base,
        secondary_inbound_window_mask,
        secondary_inbound_translate_value);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ans <= '0;
    end else begin
      out_ans <= '0;
      if (out_req.valid) begin
        if ((out_req.addr & BIG_WIN_MASK) == MEM_WIN_BASE) begin
          out_ans.kind <= PATW_OUT_MEM;
          out_ans.addr_lo <= (primary_outbound_mem_value & BIG_WIN_MASK)
            | (out_req.addr & ~BIG_WIN_MASK);
        end else if ((out_req.addr & BIG_WIN_MASK) == DUAL_WIN_BASE) begin
          out_ans.kind <= PATW_OUT_DUAL;
          out_ans.addr_lo <= (primary_outbound_dual_addr_value
            & BIG_WIN_MASK) | (out_req.addr & ~BIG_WIN_MASK);
          out_ans.addr_hi <= primary_outbound_upper_addr;
        end else if ((out_req.addr & IO_WIN_MASK) == IO_WIN_BASE) begin
          out_ans.kind <= PATW_OUT_IO;
          out_ans.addr_lo <= (primary_outbound_io_value & IO_WIN_MASK)
            | (out_req.addr & ~IO_WIN_MASK);
        end
      end
    end
  end
endmodule

//--- tb_pci_address_translation_windows.sv
`timescale 1ns/1ps
module tb_pci_address_translation_windows
  import patw_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, we, sec;
  logic [31:0] paddr = '0, pwdata = '0, prdata, wd;
  patw_req_s pri_req, sec_req, out_req;
  patw_in_ans_s pri_ans, sec_ans;
  patw_out_ans_s out_ans;
  int bad_count = 0, compares = 0;
  always #5 pclk = ~pclk;
  patw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pci_base_we(we), .pci_base_sec(sec), .pci_base_wdata(wd),
    .pri_in_req(pri_req), .sec_in_req(sec_req), .out_req(out_req),
    .pri_in_ans(pri_ans), .sec_in_ans(sec_ans), .out_ans(out_ans));
  patw_far u_far (.pclk(pclk), .pri_req(pri_req), .sec_req(sec_req),
    .out_req(out_req), .base_we(we), .base_sec(sec), .base_wdata(wd));
  // ==========================================================
  // report and checks
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic in_chk(input int unsigned w, input logic [31:0] a,
    input logic h, input logic [31:0] e);
    patw_in_ans_s r;
    u_far.send(w, a);
    #1;
    r = (w == 0) ? pri_ans : sec_ans;
    chk({31'h0, r.hit}, {31'h0, h});
    chk(r.addr, e);
  endtask
  task automatic out_chk(input logic [31:0] a, input patw_kind_e k,
    input logic [31:0] lo, input logic [31:0] hi, input logic ch);
    u_far.send(2, a);
    #1;
    chk({30'h0, out_ans.kind}, {30'h0, k});
    chk(out_ans.addr_lo, lo);
    if (ch) chk(out_ans.addr_hi, hi);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(OFS_IRQ_INFO, {LAT_RST, GNT_RST, PIN_RST, LINE_RST});
    rd(OFS_SI_MASK, 32'hffffe000);
    wr(8'h2c, 32'hffffffff);
    rd(8'h2c, 32'h0);
    wr(OFS_IRQ_INFO, 32'hffff040a);
    rd(OFS_IRQ_INFO, 32'hffff040a);
    $display("test regs done");
  endtask
  task automatic t_base();
    u_far.cfg(1'b0, 32'hffffffff);
    rd(OFS_PI_BASE, 32'h0);
    wr(OFS_PI_MASK, 32'hffff0000);
    u_far.cfg(1'b0, 32'hffffffff);
    rd(OFS_PI_BASE, 32'hffff0000);
    wr(OFS_PI_BASE, 32'habcd1234);
    rd(OFS_PI_BASE, 32'habcd0000);
    wr(OFS_SI_MASK, 32'h0);
    u_far.cfg(1'b1, 32'hffffffff);
    rd(OFS_SI_BASE, 32'h0);
    wr(OFS_SI_MASK, 32'hffffe000);
    u_far.cfg(1'b1, 32'hffffffff);
    rd(OFS_SI_BASE, 32'hffffe000);
    wr(OFS_SI_BASE, 32'h5555aaaa);
    rd(OFS_SI_BASE, 32'h5555a000);
    $display("test base done");
  endtask
  task automatic t_inbound();
    u_far.cfg(1'b0, 32'h12345678);
    rd(OFS_PI_BASE, 32'h12340000);
    wr(OFS_PI_XLAT, 32'habcd9999);
    in_chk(0, 32'h1234beef, 1'b1, 32'habcdbeef);
    in_chk(0, 32'h1235beef, 1'b0, 32'h0);
    u_far.cfg(1'b1, 32'h12340000);
    wr(OFS_SI_XLAT, 32'h5555ffff);
    in_chk(1, 32'h12341abc, 1'b1, 32'h5555fabc);
    in_chk(1, 32'h12343abc, 1'b0, 32'h0);
    $display("test inbound done");
  endtask
  task automatic t_outbound();
    wr(OFS_PO_MEM, 32'h11111111);
    wr(OFS_PO_IO, 32'h22222222);
    wr(OFS_PO_DUAL, 32'h33333333);
    wr(OFS_PO_UPPER, 32'hdeadbeef);
    out_chk(32'h81234567, PATW_OUT_MEM, 32'h11234567, 0, 0);
    out_chk(32'h9000ffff, PATW_OUT_IO, 32'h2222ffff, 0, 0);
    out_chk(32'h90010000, PATW_OUT_NONE, 0, 0, 1);
    out_chk(32'h87ffffff, PATW_OUT_DUAL, 32'h33ffffff,
      32'hdeadbeef, 1);
    out_chk(32'h88000000, PATW_OUT_NONE, 0, 0, 1);
    wr(OFS_IRQ_INFO, 32'h0000010f);
    out_chk(32'h81234567, PATW_OUT_MEM, 32'h11234567, 0, 0);
    $display("test outbound done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_base();
    t_inbound();
    t_outbound();
    stop_test();
  end
endmodule
